// [nbu_pkg.sv]
// Package with the register map, field positions and timing counts of the serial port.
package nbu_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h00;
    localparam logic [7:0] IDX_SERIAL_BUFFER  = 8'h01;
    localparam logic [7:0] IDX_POWER_CONTROL  = 8'h02;
    localparam logic [7:0] IDX_SLAVE_ADDRESS  = 8'ha9;
    localparam logic [7:0] IDX_SLAVE_MASK     = 8'hb9;

    // Field positions in serial_control_reg.
    localparam int SC_MODE_HI  = 7;
    localparam int SC_MODE_LO  = 6;
    localparam int SC_MPROC    = 5;
    localparam int SC_RX_EN    = 4;
    localparam int SC_TX_NINTH = 3;
    localparam int SC_RX_NINTH = 2;
    localparam int SC_TX_DONE  = 1;
    localparam int SC_RX_DONE  = 0;

    // Field positions in power_control_reg.
    localparam int PC_BAUD_DOUBLE = 7;
    localparam int PC_FE_VIEW     = 6;

    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Mode encodings of mode_sel_hi and mode_sel_lo.
    localparam logic [1:0] MODE_SYNC8   = 2'h0;
    localparam logic [1:0] MODE_ASYNC10 = 2'h1;
    localparam logic [1:0] MODE_OSC11   = 2'h2;
    localparam logic [1:0] MODE_TMR11   = 2'h3;

    // Sixteen-slice bit timing.
    localparam logic [3:0] DIV_LAST = 4'hf;
    localparam logic [3:0] SMP_A    = 4'h7;
    localparam logic [3:0] SMP_B    = 4'h8;
    localparam logic [3:0] SMP_C    = 4'h9;

    // Bits sent after the start bit, and index of the last received bit.
    localparam logic [3:0] TX_CNT_11 = 4'ha;
    localparam logic [3:0] TX_CNT_10 = 4'h9;
    localparam logic [3:0] RX_LAST_11 = 4'ha;
    localparam logic [3:0] RX_LAST_10 = 4'h9;

    // AHB transfer types.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // Receiver states, Gray coded along the frame.
    typedef enum logic [1:0] {
        NBU_RX_IDLE  = 2'h0,
        NBU_RX_START = 2'h1,
        NBU_RX_BITS  = 2'h3
    } nbu_rx_state_t;

    // Serial control fields as software sees them.
    typedef struct packed {
        logic mode_sel_hi;
        logic mode_sel_lo;
        logic multiproc_enable;
        logic rx_enable;
        logic tx_ninth_bit;
        logic rx_ninth_bit;
        logic tx_done_flag;
        logic rx_done_flag;
    } nbu_serial_control_reg_t;

    // Captured address phase of a bus transfer.
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] index;
    } nbu_bus_req_t;

endpackage

// [nbu_uart.sv]
// Nine-bit asynchronous serial port with address recognition behind an AHB-Lite slave.
//
// How it works
// - Eleven-bit frame: start low, eight data bits LSB first, ninth bit, stop.
// - Received ninth bit goes into rx_ninth_bit.
// - Mode 2 bit rate is oscillator/16 or /32, picked by baud_double_sel.
// - Buffer write starts sending; each bit leaves at a divide-by-16 rollover.
// - tx_done_flag rises at the eleventh rollover after the buffer write.
// - With rx_enable high, input watched at sixteen times bit rate for falling edge.
// - Falling edge resets receive divide-by-16 counter, aligning bit boundaries.
// - Each bit is the majority of samples at counter states seven, eight, nine.
// - Start bit sampled high aborts the frame and resumes edge search.
// - Frame stored only if rx_done_flag clear and multiproc off or bit one.
// - Edge search resumes in the middle of the stop bit.
// - Mode 3 equals mode 2 but clocked by the timer overflow.
// - Mode codes: 00 sync, 01 ten-bit async, 10 and 11 eleven-bit async; 00 here only holds the line high and the receiver idle.
// - frame_error_flag sets when a frame has no valid stop bit.
// - Control bit 7 shows frame_error_flag or mode_sel_hi by frame_error_view_sel.
// - frame_error_flag is sticky; only a software write clears it.
// - With multiproc on, an address byte sets rx_done_flag only on address match.
// - Mode 1 with multiproc needs a valid stop bit and an address match.
// - Given address compares only bits where the mask holds one.
// - Broadcast address is address OR mask; its zero bits are don't-care.
// - Both address registers reset to zero, making every bit don't-care.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module nbu_uart (
    // Clock and reset.
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RST,
    // AHB-Lite slave.
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic      [31:0] O_HRDATA,
    output logic             O_HREADYOUT,
    output logic             O_HRESP,
    // Baud source and serial pins.
    input  wire logic        I_TIMER_OVF,
    input  wire logic        I_SERIAL_IN,
    output logic             O_SERIAL_OUT,
    // Interrupt request toward the core.
    output logic             O_SERIAL_IRQ
);

    ////////////////////////////////////////////////////////////////////////////////
    // Functions.

    // Best of three samples.
    function automatic logic vote3(input logic [2:0] s);
        vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    // Given or broadcast address match.
    function automatic logic addr_match(input logic [7:0] rx, input logic [7:0] adr,
                                        input logic [7:0] msk);
        logic [7:0] bcast;
        bcast = adr | msk;
        addr_match = (((rx ^ adr) & msk) == 8'h00)
                   | (((rx ^ bcast) & bcast) == 8'h00);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Bus address phase capture.

    nbu_pkg::nbu_bus_req_t bus_req;
    nbu_pkg::nbu_bus_req_t next_bus_req;
    logic [7:0]            rd_byte;
    logic [31:0]           next_hrdata;

    always_comb begin
        next_bus_req.valid = I_HSEL & I_HREADY & (I_HTRANS == nbu_pkg::HTRANS_NONSEQ);
        next_bus_req.write = I_HWRITE;
        next_bus_req.index = (I_HADDR[31:10] == 22'h000000 && I_HADDR[1:0] == 2'h0)
                           ? I_HADDR[9:2] : 8'hff;
        next_hrdata = (next_bus_req.valid && !I_HWRITE) ? {24'h000000, rd_byte} : O_HRDATA;
    end

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            bus_req  <= '0;
            O_HRDATA <= 32'h00000000;
        end else begin
            bus_req  <= next_bus_req;
            O_HRDATA <= next_hrdata;
        end
    end

    assign O_HREADYOUT = 1'b1;
    assign O_HRESP     = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchroniser.

    logic rx_meta;
    logic rx_sync;

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= I_SERIAL_IN;
            rx_sync <= rx_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers, transmitter and receiver state.

    nbu_pkg::nbu_serial_control_reg_t      serial_control_reg;
    logic                    frame_error_flag;
    logic [7:0]              serial_buffer;
    logic [7:0]              tx_hold;
    logic                    baud_double_sel;
    logic                    frame_error_view_sel;
    logic [7:0]              slave_address;
    logic [7:0]              slave_address_mask;
    logic                    half_tick;
    logic [3:0]              tx_div;
    logic                    tx_pend;
    logic                    tx_busy;
    logic [9:0]              tx_shift;
    logic [3:0]              tx_cnt;
    logic                    tx_line;
    nbu_pkg::nbu_rx_state_t  rx_state;
    logic                    rx_last;
    logic [3:0]              rx_div;
    logic [3:0]              rx_idx;
    logic [2:0]              rx_smp;
    logic [7:0]              rx_data;
    logic                    rx_ninth;

    nbu_pkg::nbu_serial_control_reg_t      next_serial_control_reg;
    logic                    next_frame_error_flag;
    logic [7:0]              next_serial_buffer;
    logic [7:0]              next_tx_hold;
    logic                    next_baud_double_sel;
    logic                    next_frame_error_view_sel;
    logic [7:0]              next_slave_address;
    logic [7:0]              next_slave_address_mask;
    logic                    next_half_tick;
    logic [3:0]              next_tx_div;
    logic                    next_tx_pend;
    logic                    next_tx_busy;
    logic [9:0]              next_tx_shift;
    logic [3:0]              next_tx_cnt;
    logic                    next_tx_line;
    nbu_pkg::nbu_rx_state_t  next_rx_state;
    logic                    next_rx_last;
    logic [3:0]              next_rx_div;
    logic [3:0]              next_rx_idx;
    logic [2:0]              next_rx_smp;
    logic [7:0]              next_rx_data;
    logic                    next_rx_ninth;

    logic [1:0] mode;
    logic       async_on;
    logic       base_tick;
    logic       tick;
    logic       wr;
    logic [7:0] wbyte;
    logic       bit_val;
    logic [3:0] rx_last_idx;
    logic       qual_bit;

    always_comb begin
        mode     = {serial_control_reg.mode_sel_hi, serial_control_reg.mode_sel_lo};
        async_on = (mode != nbu_pkg::MODE_SYNC8);
        // Oscillator rate in mode 2, timer overflow in modes 1 and 3.
        base_tick = (mode == nbu_pkg::MODE_OSC11) ? 1'b1 : I_TIMER_OVF;
        tick      = base_tick & (baud_double_sel | half_tick);
        wr        = bus_req.valid & bus_req.write;
        wbyte     = I_HWDATA[7:0];
        rx_last_idx = (mode == nbu_pkg::MODE_ASYNC10) ? nbu_pkg::RX_LAST_10
                                                      : nbu_pkg::RX_LAST_11;

        next_serial_control_reg                 = serial_control_reg;
        next_frame_error_flag     = frame_error_flag;
        next_serial_buffer        = serial_buffer;
        next_tx_hold              = tx_hold;
        next_baud_double_sel      = baud_double_sel;
        next_frame_error_view_sel = frame_error_view_sel;
        next_slave_address        = slave_address;
        next_slave_address_mask   = slave_address_mask;
        next_half_tick            = base_tick ? ~half_tick : half_tick;
        next_tx_div               = tick ? tx_div + 4'h1 : tx_div;
        next_tx_pend              = tx_pend;
        next_tx_busy              = tx_busy;
        next_tx_shift             = tx_shift;
        next_tx_cnt               = tx_cnt;
        next_tx_line              = tx_line;
        next_rx_state             = rx_state;
        next_rx_last              = tick ? rx_sync : rx_last;
        next_rx_div               = rx_div;
        next_rx_idx               = rx_idx;
        next_rx_smp               = rx_smp;
        next_rx_data              = rx_data;
        next_rx_ninth             = rx_ninth;
        bit_val                   = vote3(rx_smp);
        qual_bit                  = 1'b0;

        // Software writes; hardware sets below take priority.
        if (wr) begin
            unique case (bus_req.index)
                nbu_pkg::IDX_SERIAL_CONTROL: begin
                    if (frame_error_view_sel) begin
                        next_frame_error_flag = wbyte[nbu_pkg::SC_MODE_HI];
                    end else begin
                        next_serial_control_reg.mode_sel_hi = wbyte[nbu_pkg::SC_MODE_HI];
                    end
                    next_serial_control_reg.mode_sel_lo      = wbyte[nbu_pkg::SC_MODE_LO];
                    next_serial_control_reg.multiproc_enable = wbyte[nbu_pkg::SC_MPROC];
                    next_serial_control_reg.rx_enable        = wbyte[nbu_pkg::SC_RX_EN];
                    next_serial_control_reg.tx_ninth_bit     = wbyte[nbu_pkg::SC_TX_NINTH];
                    next_serial_control_reg.rx_ninth_bit     = wbyte[nbu_pkg::SC_RX_NINTH];
                    next_serial_control_reg.tx_done_flag     = wbyte[nbu_pkg::SC_TX_DONE];
                    next_serial_control_reg.rx_done_flag     = wbyte[nbu_pkg::SC_RX_DONE];
                end
                nbu_pkg::IDX_SERIAL_BUFFER: begin
                    next_tx_hold = wbyte;
                    next_tx_pend = async_on;
                end
                nbu_pkg::IDX_POWER_CONTROL: begin
                    next_baud_double_sel      = wbyte[nbu_pkg::PC_BAUD_DOUBLE];
                    next_frame_error_view_sel = wbyte[nbu_pkg::PC_FE_VIEW];
                end
                nbu_pkg::IDX_SLAVE_ADDRESS: next_slave_address = wbyte;
                nbu_pkg::IDX_SLAVE_MASK:    next_slave_address_mask = wbyte;
                default: begin
                end
            endcase
        end

        // Transmitter: every bit leaves at a rollover of the divide-by-16 counter.
        if (tick && tx_div == nbu_pkg::DIV_LAST) begin
            if (tx_busy) begin
                next_tx_line  = tx_shift[0];
                next_tx_shift = {1'b1, tx_shift[9:1]};
                next_tx_cnt   = tx_cnt - 4'h1;
                if (tx_cnt == 4'h1) begin
                    next_tx_busy = 1'b0;
                    next_serial_control_reg.tx_done_flag = 1'b1;
                end
            end else if (tx_pend && async_on) begin
                next_tx_line  = 1'b0;
                next_tx_pend  = 1'b0;
                next_tx_busy  = 1'b1;
                if (mode == nbu_pkg::MODE_ASYNC10) begin
                    next_tx_shift = {2'h3, tx_hold};
                    next_tx_cnt   = nbu_pkg::TX_CNT_10;
                end else begin
                    next_tx_shift = {1'b1, serial_control_reg.tx_ninth_bit, tx_hold};
                    next_tx_cnt   = nbu_pkg::TX_CNT_11;
                end
            end
        end
        if (!async_on) begin
            next_tx_busy = 1'b0;
            next_tx_line = 1'b1;
        end

        // Receiver.
        unique case (rx_state)
            nbu_pkg::NBU_RX_IDLE: begin
                if (tick && serial_control_reg.rx_enable && async_on && rx_last && !rx_sync) begin
                    next_rx_state = nbu_pkg::NBU_RX_START;
                    next_rx_div   = 4'h0;
                    next_rx_idx   = 4'h0;
                end
            end
            nbu_pkg::NBU_RX_START, nbu_pkg::NBU_RX_BITS: begin
                if (tick) begin
                    next_rx_div = rx_div + 4'h1;
                    if (rx_div == nbu_pkg::SMP_A) next_rx_smp[0] = rx_sync;
                    if (rx_div == nbu_pkg::SMP_B) next_rx_smp[1] = rx_sync;
                    if (rx_div == nbu_pkg::SMP_C) begin
                        bit_val     = vote3({rx_sync, rx_smp[1:0]});
                        next_rx_idx = rx_idx + 4'h1;
                        if (rx_state == nbu_pkg::NBU_RX_START) begin
                            next_rx_state = bit_val ? nbu_pkg::NBU_RX_IDLE
                                                    : nbu_pkg::NBU_RX_BITS;
                        end else if (rx_idx < 4'h9) begin
                            next_rx_data = {bit_val, rx_data[7:1]};
                        end else if (rx_idx != rx_last_idx) begin
                            next_rx_ninth = bit_val;
                        end else begin
                            // Middle of the stop bit: decide and search again.
                            next_rx_state = nbu_pkg::NBU_RX_IDLE;
                            qual_bit = (mode == nbu_pkg::MODE_ASYNC10) ? bit_val : rx_ninth;
                            if (!bit_val) begin
                                next_frame_error_flag = 1'b1;
                            end
                            if (!serial_control_reg.rx_done_flag
                                && (!serial_control_reg.multiproc_enable
                                    || (qual_bit && bit_val
                                        && addr_match(rx_data, slave_address,
                                                      slave_address_mask)))) begin
                                next_serial_control_reg.rx_ninth_bit = qual_bit;
                                next_serial_buffer     = rx_data;
                                next_serial_control_reg.rx_done_flag = 1'b1;
                            end
                        end
                    end
                end
                if (!serial_control_reg.rx_enable || !async_on) begin
                    next_rx_state = nbu_pkg::NBU_RX_IDLE;
                end
            end
            default: next_rx_state = nbu_pkg::NBU_RX_IDLE;
        endcase

        // Register read view for the next data phase.
        unique case (next_bus_req.index)
            nbu_pkg::IDX_SERIAL_CONTROL: rd_byte = {frame_error_view_sel ? frame_error_flag
                                                                         : serial_control_reg.mode_sel_hi,
                                                    serial_control_reg[6:0]};
            nbu_pkg::IDX_SERIAL_BUFFER:  rd_byte = serial_buffer;
            nbu_pkg::IDX_POWER_CONTROL:  rd_byte = {baud_double_sel, frame_error_view_sel,
                                                    6'h00};
            nbu_pkg::IDX_SLAVE_ADDRESS:  rd_byte = slave_address;
            nbu_pkg::IDX_SLAVE_MASK:     rd_byte = slave_address_mask;
            default:                     rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            serial_control_reg                 <= '0;
            frame_error_flag     <= 1'b0;
            serial_buffer        <= nbu_pkg::RST_BYTE;
            tx_hold              <= nbu_pkg::RST_BYTE;
            baud_double_sel      <= 1'b0;
            frame_error_view_sel <= 1'b0;
            slave_address        <= nbu_pkg::RST_BYTE;
            slave_address_mask   <= nbu_pkg::RST_BYTE;
            half_tick            <= 1'b0;
            tx_div               <= 4'h0;
            tx_pend              <= 1'b0;
            tx_busy              <= 1'b0;
            tx_shift             <= 10'h3ff;
            tx_cnt               <= 4'h0;
            tx_line              <= 1'b1;
            rx_state             <= nbu_pkg::NBU_RX_IDLE;
            rx_last              <= 1'b1;
            rx_div               <= 4'h0;
            rx_idx               <= 4'h0;
            rx_smp               <= 3'h0;
            rx_data              <= 8'h00;
            rx_ninth             <= 1'b0;
        end else begin
            serial_control_reg                 <= next_serial_control_reg;
            frame_error_flag     <= next_frame_error_flag;
            serial_buffer        <= next_serial_buffer;
            tx_hold              <= next_tx_hold;
            baud_double_sel      <= next_baud_double_sel;
            frame_error_view_sel <= next_frame_error_view_sel;
            slave_address        <= next_slave_address;
            slave_address_mask   <= next_slave_address_mask;
            half_tick            <= next_half_tick;
            tx_div               <= next_tx_div;
            tx_pend              <= next_tx_pend;
            tx_busy              <= next_tx_busy;
            tx_shift             <= next_tx_shift;
            tx_cnt               <= next_tx_cnt;
            tx_line              <= next_tx_line;
            rx_state             <= next_rx_state;
            rx_last              <= next_rx_last;
            rx_div               <= next_rx_div;
            rx_idx               <= next_rx_idx;
            rx_smp               <= next_rx_smp;
            rx_data              <= next_rx_data;
            rx_ninth             <= next_rx_ninth;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign O_SERIAL_OUT = tx_line;
    assign O_SERIAL_IRQ = serial_control_reg.tx_done_flag | serial_control_reg.rx_done_flag;

endmodule

`default_nettype wire

// [nbu_uart_checker.sv]
// Concurrent checks on the serial port's bus answers and pin behaviour.
`timescale 1ns/1ps
`default_nettype none
module nbu_uart_checker (
    // Clock, reset and bus inputs.
    input wire logic        I_SYS_CLK, I_RST, I_HSEL, I_HWRITE, I_HREADY,
    input wire logic [1:0]  I_HTRANS,
    // Outputs watched.
    input wire logic [31:0] O_HRDATA,
    input wire logic        O_HREADYOUT, O_HRESP, O_SERIAL_OUT, O_SERIAL_IRQ
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);
    logic taken;
    assign taken = I_HSEL && I_HREADY && I_HTRANS == nbu_pkg::HTRANS_NONSEQ;
    a_ready_high: assert property (O_HREADYOUT) else $error("hreadyout low");
    a_resp_okay: assert property (!O_HRESP) else $error("hresp not okay");
    a_rdata_upper: assert property (O_HRDATA[31:8] == 24'h0) else $error("hrdata upper set");
    a_rdata_hold: assert property (!$past(taken && !I_HWRITE) |-> $stable(O_HRDATA))
        else $error("hrdata changed without a read");
    a_low_width: assert property ($fell(O_SERIAL_OUT) |=> !O_SERIAL_OUT [*8])
        else $error("low bit shorter than a bit time");
    a_high_width: assert property ($rose(O_SERIAL_OUT) |=> O_SERIAL_OUT [*8])
        else $error("high bit shorter than a bit time");
    a_irq_clear: assert property ($fell(O_SERIAL_IRQ) |-> $past(taken && I_HWRITE, 2))
        else $error("interrupt dropped without a write");
    a_reset_idle: assert property ($fell(I_RST) |-> O_SERIAL_OUT && !O_SERIAL_IRQ)
        else $error("outputs not idle after reset");
    c_tx: cover property ($fell(O_SERIAL_OUT));
    c_irq: cover property ($rose(O_SERIAL_IRQ));
    c_read: cover property (taken && !I_HWRITE);
endmodule
bind nbu_uart nbu_uart_checker u_chk (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_HSEL(I_HSEL),
    .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY), .I_HTRANS(I_HTRANS), .O_HRDATA(O_HRDATA),
    .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_SERIAL_OUT(O_SERIAL_OUT),
    .O_SERIAL_IRQ(O_SERIAL_IRQ));
`default_nettype wire

// [nbu_node.sv]
// Remote serial node that sends and captures eleven-bit characters.
`timescale 1ns/1ps
`default_nettype none
module nbu_node #(parameter int BIT = 16) (
    // Clock and serial lines.
    input  wire logic clk,
    input  wire logic rxd,
    output var  logic txd
);
    logic [9:0] cap[$];
    logic [9:0] sh;
    initial txd = 1'b1;
    // Start low, data LSB first, ninth bit, stop, then one idle bit time high.
    task automatic send(input logic [7:0] d, input logic n, input logic s);
        logic [10:0] f;
        f = {s, n, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk);
            txd <= f[i];
            repeat (BIT - 1) @(posedge clk);
        end
        @(posedge clk);
        txd <= 1'b1;
        repeat (BIT) @(posedge clk);
    endtask
    // Samples each device frame in mid-bit as stop, ninth and data.
    always begin
        @(negedge rxd);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            repeat (BIT) @(posedge clk);
            sh[i] = rxd;
        end
        cap.push_back(sh);
    end
endmodule
`default_nettype wire

// [tb.sv]
// Testbench for the nine-bit serial port: bus, transmit, receive and address filter.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [7:0] SC = nbu_pkg::IDX_SERIAL_CONTROL;
    localparam logic [7:0] SB = nbu_pkg::IDX_SERIAL_BUFFER;
    localparam logic [7:0] PC = nbu_pkg::IDX_POWER_CONTROL;
    logic        clk, rst, hsel, hwrite, hready, hresp, sout, sin, irq, acc, ovf, fast;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic [9:0]  exp_tx[$];
    logic [8:0]  cases[5];
    logic [7:0]  b;
    int          n_fail, n_checks, k;
    nbu_uart dut (.I_SYS_CLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
        .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
        .I_TIMER_OVF(ovf), .I_SERIAL_IN(sin), .O_SERIAL_OUT(sout), .O_SERIAL_IRQ(irq));
    nbu_node #(.BIT(16)) node (.clk(clk), .rxd(sout), .txd(sin));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= nbu_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
        hsel <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, idx, d, r);
    endtask
    task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] m,
                       input logic [7:0] e);
        logic [31:0] r;
        bus(1'b0, idx, 8'h00, r);
        chk(nm, r & {24'hffffff, m}, {24'h0, e});
    endtask
    task automatic txt(input logic [7:0] sc, input logic [7:0] pc, input logic [7:0] d,
                       input int lo, input int hi);
        wr(PC, pc);
        wr(SC, sc);
        wr(SB, d);
        k = 0;
        while (irq !== 1'b1 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        chk("tx_done_time", 32'(k >= lo && k <= hi), 32'h1);
    endtask
    function automatic logic hit(input logic [7:0] d, input logic [7:0] a, input logic [7:0] m);
        return ((d & m) == (a & m)) || ((d & (a | m)) == (a | m));
    endfunction
    task results;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Timer overflow pulses every other clock, or every clock once fast is set.
    always @(posedge clk) ovf <= (ovf === 1'b0) | fast;
    initial begin
        repeat (30000) @(posedge clk);
        n_fail++;
        results();
    end
    initial begin
        {rst, fast, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 69'h0};
        {n_fail, n_checks} = 0;
        cases = '{9'h1a0, 9'h1a3, 9'h1ff, 9'h0a0, 9'h100};
        void'($urandom(1367));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdc("slave_addr_reg_rst", nbu_pkg::IDX_SLAVE_ADDRESS, 8'hff, 8'h00);
        rdc("smask_rst", nbu_pkg::IDX_SLAVE_MASK, 8'hff, 8'h00);
        rdc("unmapped", 8'h50, 8'hff, 8'h00);
        b = 8'($urandom);
        exp_tx.push_back({2'h3, b});
        txt(8'h98, 8'h80, b, 162, 177);
        repeat (24) @(posedge clk);
        chk("tx_frame", 32'(node.cap.pop_front()), 32'(exp_tx.pop_front()));
        rdc("tx_flag", SC, 8'hff, 8'h9a);
        txt(8'h80, 8'h00, 8'($urandom), 322, 353);
        txt(8'hc0, 8'h80, 8'($urandom), 322, 353);
        txt(8'h40, 8'h80, 8'($urandom), 290, 321);
        fast <= 1'b1;
        wr(nbu_pkg::IDX_SLAVE_ADDRESS, 8'ha4);
        wr(nbu_pkg::IDX_SLAVE_MASK, 8'hfa);
        wr(SC, 8'hf0);
        cases[4] = {1'b1, 8'($urandom)};
        foreach (cases[i]) begin
            node.send(cases[i][7:0], cases[i][8], 1'b1);
            acc = cases[i][8] && hit(cases[i][7:0], 8'ha4, 8'hfa);
            rdc("rx_flag", SC, acc ? 8'hff : 8'hfb, acc ? 8'hf5 : 8'hf0);
            if (acc)
                rdc("rx_data", SB, 8'hff, cases[i][7:0]);
            wr(SC, 8'hf0);
        end
        wr(SC, 8'h90);
        wr(PC, 8'hc0);
        node.send(8'h3c, 1'b0, 1'b0);
        rdc("fe_set", SC, 8'hff, 8'h91);
        node.send(8'h55, 1'b1, 1'b1);
        rdc("fe_sticky", SC, 8'hff, 8'h91);
        rdc("rx_kept", SB, 8'hff, 8'h3c);
        wr(SC, 8'h10);
        rdc("fe_clr", SC, 8'hff, 8'h10);
        wr(PC, 8'h80);
        rdc("mode_hi", SC, 8'hff, 8'h90);
        wr(SC, 8'h70);
        node.send(8'ha0, 1'b1, 1'b1);
        rdc("m1_addr", SC, 8'hff, 8'h75);
        rdc("m1_data", SB, 8'hff, 8'ha0);
        wr(SC, 8'h70);
        node.send(8'ha4, 1'b0, 1'b1);
        rdc("m1_bad_stop", SC, 8'hff, 8'h70);
        results();
    end
endmodule
`default_nettype wire
